// file: hdl/sbc_ctrl.sv
// two-wire serial bus slave engine with its control register and register port
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// - module_on hands the clock and data pins to the engine; clear disables it and frees the pins.
// - idle_halt set freezes the engine while the device is idle; clear keeps it running in idle.
// - as slave, clock_release set lets the clock line go, clear holds it low while a transfer is in progress; it resets set.
// - with stretch_allow set software writes 0 or 1; hardware clears it at each transmit byte start and address or data byte end.
// - with stretch_allow clear software can only write 1; hardware clears it at transmit byte start and address byte end.
// - accept_all_addresses set acknowledges every address; clear keeps normal matching.
// - wide_address_select set makes own_address a 10-bit address, clear a 7-bit one.
// - broadcast_call_enable set with reception on flags the general call address; clear ignores it.
module sbc_ctrl (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic idle_in,
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic [15:0] rdata_out,
   output logic irq_out,
   output logic pins_owned_out,
   output logic scl_out,
   output logic scl_oe_out,
   output logic sda_out,
   output logic sda_oe_out
);
   // ****************************************************************
   // state
   // ****************************************************************
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic [9:0] own_addr_reg;
   logic [4:0] status_reg;
   logic [4:0] status_next;
   logic [4:0] mask_reg;
   logic [7:0] rx_data_reg;
   logic [7:0] tx_data_reg;
   logic [15:0] rdata_reg;
   logic irq_reg;
   logic pins_owned_reg;
   logic scl_oe_reg;
   logic sda_oe_reg;
   logic sda_oe_next;
   logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
   logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
   sbc_pkg::sbc_state_t state_reg;
   sbc_pkg::sbc_state_t state_next;
   logic [3:0] bitcnt_reg;
   logic [3:0] bitcnt_next;
   logic [7:0] rx_shift_reg;
   logic [7:0] rx_shift_next;
   logic [7:0] tx_shift_reg;
   logic [7:0] tx_shift_next;
   logic second_reg, second_next;
   logic ten_hit_reg, ten_hit_next;
   logic ack_reg, ack_next;
   logic rx_load;
   logic hw_rel_clr;
   logic [4:0] ev_set;

   // ****************************************************************
   // decoding
   // ****************************************************************
   wire ctrl_wr = wr_in && (addr_in == sbc_pkg::OFF_CONTROL);
   wire own_wr = wr_in && (addr_in == sbc_pkg::OFF_OWN_ADDR);
   wire status_wr = wr_in && (addr_in == sbc_pkg::OFF_STATUS);
   wire mask_wr = wr_in && (addr_in == sbc_pkg::OFF_MASK);
   wire tx_wr = wr_in && (addr_in == sbc_pkg::OFF_TX_DATA);
   wire mod_on = ctrl_reg[sbc_pkg::CTL_ON];
   wire halted = mod_on && ctrl_reg[sbc_pkg::CTL_IDLE_HALT] && idle_in;
   wire eng_en = ce_in && !halted;
   wire scl_rise = scl_sync_reg && !scl_prev_reg;
   wire scl_fall = !scl_sync_reg && scl_prev_reg;
   wire start_det = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
   wire stop_det = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;
   wire byte_end = scl_fall && (bitcnt_reg == sbc_pkg::BITS_PER_BYTE);
   wire accept_all = ctrl_reg[sbc_pkg::CTL_ACCEPT_ALL];
   wire wide = ctrl_reg[sbc_pkg::CTL_WIDE];
   wire is_bcast = ctrl_reg[sbc_pkg::CTL_BCAST] && (rx_shift_reg == sbc_pkg::BCAST_ADDR);
   wire seven_hit = rx_shift_reg[7:1] == own_addr_reg[6:0];
   wire ten_first = (rx_shift_reg[7:3] == sbc_pkg::TEN_BIT_PREFIX) && (rx_shift_reg[2:1] == own_addr_reg[9:8]);
   // a 10-bit read is only answered after a full 10-bit write match
   wire ten_hit = ten_first && (!rx_shift_reg[0] || ten_hit_reg);
   wire addr_hit = accept_all || is_bcast || (wide ? ten_hit : seven_hit);
   wire addr_second = !accept_all && !is_bcast && wide && !rx_shift_reg[0];

   // ****************************************************************
   // slave engine
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      bitcnt_next = bitcnt_reg;
      rx_shift_next = rx_shift_reg;
      tx_shift_next = tx_shift_reg;
      sda_oe_next = sda_oe_reg;
      second_next = second_reg;
      ten_hit_next = ten_hit_reg;
      ack_next = ack_reg;
      rx_load = 1'b0;
      hw_rel_clr = 1'b0;
      ev_set = 5'h00;
      if (!mod_on) begin
         state_next = sbc_pkg::ST_IDLE;
         sda_oe_next = 1'b0;
         ten_hit_next = 1'b0;
         bitcnt_next = 4'h0;
      end else if (stop_det) begin
         state_next = sbc_pkg::ST_IDLE;
         sda_oe_next = 1'b0;
         ten_hit_next = 1'b0;
         ev_set[sbc_pkg::EV_STOP] = state_reg != sbc_pkg::ST_IDLE;
      end else if (start_det) begin
         // repeated start keeps ten_hit so a 10-bit read can follow
         state_next = sbc_pkg::ST_ADDR;
         bitcnt_next = 4'h0;
         sda_oe_next = 1'b0;
      end else begin
         if (scl_rise) begin
            bitcnt_next = bitcnt_reg + 4'h1;
            if (state_reg == sbc_pkg::ST_ADDR || state_reg == sbc_pkg::ST_ADDR2 || state_reg == sbc_pkg::ST_RX) begin
               rx_shift_next = {rx_shift_reg[6:0], sda_sync_reg};
            end
            if (state_reg == sbc_pkg::ST_TX_ACK) begin
               ack_next = !sda_sync_reg;
            end
         end
         if (scl_fall) begin
            case (state_reg)
               sbc_pkg::ST_ADDR: begin
                  if (byte_end) begin
                     bitcnt_next = 4'h0;
                     if (addr_hit) begin
                        state_next = sbc_pkg::ST_ADDR_ACK;
                        sda_oe_next = 1'b1;
                        second_next = addr_second;
                     end else begin
                        state_next = sbc_pkg::ST_IDLE;
                     end
                  end
               end
               sbc_pkg::ST_ADDR_ACK: begin
                  bitcnt_next = 4'h0;
                  sda_oe_next = 1'b0;
                  hw_rel_clr = 1'b1;
                  if (second_reg) begin
                     state_next = sbc_pkg::ST_ADDR2;
                  end else begin
                     ev_set[sbc_pkg::EV_BCAST] = is_bcast;
                     ev_set[sbc_pkg::EV_ADDR] = !is_bcast;
                     if (rx_shift_reg[0]) begin
                        state_next = sbc_pkg::ST_TX;
                        tx_shift_next = {tx_data_reg[6:0], 1'b0};
                        sda_oe_next = !tx_data_reg[7];
                        ev_set[sbc_pkg::EV_TX] = 1'b1;
                     end else begin
                        state_next = sbc_pkg::ST_RX;
                     end
                  end
               end
               sbc_pkg::ST_ADDR2: begin
                  if (byte_end) begin
                     bitcnt_next = 4'h0;
                     if (rx_shift_reg == own_addr_reg[7:0]) begin
                        state_next = sbc_pkg::ST_ADDR2_ACK;
                        sda_oe_next = 1'b1;
                        ten_hit_next = 1'b1;
                     end else begin
                        state_next = sbc_pkg::ST_IDLE;
                     end
                  end
               end
               sbc_pkg::ST_ADDR2_ACK: begin
                  bitcnt_next = 4'h0;
                  sda_oe_next = 1'b0;
                  hw_rel_clr = 1'b1;
                  ev_set[sbc_pkg::EV_ADDR] = 1'b1;
                  state_next = sbc_pkg::ST_RX;
               end
               sbc_pkg::ST_RX: begin
                  if (byte_end) begin
                     bitcnt_next = 4'h0;
                     rx_load = 1'b1;
                     ev_set[sbc_pkg::EV_RX] = 1'b1;
                     sda_oe_next = 1'b1;
                     state_next = sbc_pkg::ST_RX_ACK;
                  end
               end
               sbc_pkg::ST_RX_ACK: begin
                  bitcnt_next = 4'h0;
                  sda_oe_next = 1'b0;
                  hw_rel_clr = ctrl_reg[sbc_pkg::CTL_STRETCH];
                  state_next = sbc_pkg::ST_RX;
               end
               sbc_pkg::ST_TX: begin
                  if (byte_end) begin
                     bitcnt_next = 4'h0;
                     sda_oe_next = 1'b0;
                     state_next = sbc_pkg::ST_TX_ACK;
                  end else begin
                     sda_oe_next = !tx_shift_reg[7];
                     tx_shift_next = {tx_shift_reg[6:0], 1'b0};
                  end
               end
               sbc_pkg::ST_TX_ACK: begin
                  bitcnt_next = 4'h0;
                  if (ack_reg) begin
                     state_next = sbc_pkg::ST_TX;
                     tx_shift_next = {tx_data_reg[6:0], 1'b0};
                     sda_oe_next = !tx_data_reg[7];
                     hw_rel_clr = 1'b1;
                     ev_set[sbc_pkg::EV_TX] = 1'b1;
                  end else begin
                     state_next = sbc_pkg::ST_IDLE;
                  end
               end
               default: begin
                  state_next = sbc_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // register next values
   // ****************************************************************
   // a software release wins over a hardware clear in the same cycle
   wire rel_sw_set = ctrl_wr && wdata_in[sbc_pkg::CTL_RELEASE];
   wire rel_sw_clr = ctrl_wr && !wdata_in[sbc_pkg::CTL_RELEASE] && ctrl_reg[sbc_pkg::CTL_STRETCH];
   wire rel_next = rel_sw_set || (ctrl_reg[sbc_pkg::CTL_RELEASE] && !rel_sw_clr && !(eng_en && hw_rel_clr));
   wire [15:0] ctrl_base = ctrl_wr ? (wdata_in & sbc_pkg::CTL_WRITABLE) : ctrl_reg;
   assign ctrl_next = (ctrl_base & ~sbc_pkg::CTL_RELEASE_MASK) | (rel_next ? sbc_pkg::CTL_RELEASE_MASK : 16'h0000);
   // set wins over write-one-to-clear
   assign status_next = (status_reg & ~(status_wr ? wdata_in[4:0] : 5'h00)) | (eng_en ? ev_set : 5'h00);
   // stretching only while the engine is in a transfer
   wire scl_oe_next = mod_on && (state_next != sbc_pkg::ST_IDLE) && !rel_next;
   wire [15:0] rd_mux =
      (addr_in == sbc_pkg::OFF_CONTROL) ? ctrl_reg :
      (addr_in == sbc_pkg::OFF_OWN_ADDR) ? {6'h00, own_addr_reg} :
      (addr_in == sbc_pkg::OFF_STATUS) ? {11'h000, status_reg} :
      (addr_in == sbc_pkg::OFF_MASK) ? {11'h000, mask_reg} :
      (addr_in == sbc_pkg::OFF_RX_DATA) ? {8'h00, rx_data_reg} :
      (addr_in == sbc_pkg::OFF_TX_DATA) ? {8'h00, tx_data_reg} : 16'h0000;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else if (ce_in) begin
         scl_meta_reg <= scl_in;
         scl_sync_reg <= scl_meta_reg;
         scl_prev_reg <= scl_sync_reg;
         sda_meta_reg <= sda_in;
         sda_sync_reg <= sda_meta_reg;
         sda_prev_reg <= sda_sync_reg;
      end
   end

   // ****************************************************************
   // engine registers
   // ****************************************************************
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg <= sbc_pkg::ST_IDLE;
         bitcnt_reg <= 4'h0;
         rx_shift_reg <= 8'h00;
         tx_shift_reg <= 8'h00;
         sda_oe_reg <= 1'b0;
         second_reg <= 1'b0;
         ten_hit_reg <= 1'b0;
         ack_reg <= 1'b0;
         rx_data_reg <= 8'h00;
      end else if (eng_en) begin
         state_reg <= state_next;
         bitcnt_reg <= bitcnt_next;
         rx_shift_reg <= rx_shift_next;
         tx_shift_reg <= tx_shift_next;
         sda_oe_reg <= sda_oe_next;
         second_reg <= second_next;
         ten_hit_reg <= ten_hit_next;
         ack_reg <= ack_next;
         if (rx_load) begin
            rx_data_reg <= rx_shift_reg;
         end
      end
   end

   // ****************************************************************
   // register file and outputs
   // ****************************************************************
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl_reg <= sbc_pkg::CTL_RESET;
         own_addr_reg <= sbc_pkg::OWN_ADDR_RESET;
         status_reg <= 5'h00;
         mask_reg <= 5'h00;
         tx_data_reg <= sbc_pkg::TX_DATA_RESET;
         rdata_reg <= 16'h0000;
         irq_reg <= 1'b0;
         pins_owned_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
      end else if (ce_in) begin
         ctrl_reg <= ctrl_next;
         status_reg <= status_next;
         rdata_reg <= rd_in ? rd_mux : 16'h0000;
         irq_reg <= |(status_reg & mask_reg);
         pins_owned_reg <= mod_on;
         if (!halted) begin
            scl_oe_reg <= scl_oe_next;
         end
         if (own_wr) begin
            own_addr_reg <= wdata_in[9:0];
         end
         if (mask_wr) begin
            mask_reg <= wdata_in[4:0];
         end
         if (tx_wr) begin
            tx_data_reg <= wdata_in[7:0];
         end
      end
   end

   assign rdata_out = rdata_reg;
   assign irq_out = irq_reg;
   assign pins_owned_out = pins_owned_reg;
   assign scl_oe_out = scl_oe_reg;
   assign sda_oe_out = sda_oe_reg;
   // open-drain: the pins only ever drive low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   // ****************************************************************
   // assertions
   // ****************************************************************
   a_off_pins_free: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (ce_in && !mod_on) |=> (!scl_oe_out && !sda_oe_out && !pins_owned_out))
      else $error("pins still driven while module is off");

   a_on_pins_owned: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (ce_in && mod_on) |=> pins_owned_out)
      else $error("pins not handed over while module is on");

   a_idle_halt_freeze: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (ce_in && halted) |=> ($stable(state_reg) && $stable(bitcnt_reg) && $stable(sda_oe_out)))
      else $error("engine moved while halted in idle");

   a_idle_keeps_running: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (ce_in && mod_on && !ctrl_reg[sbc_pkg::CTL_IDLE_HALT] && idle_in && start_det)
      |=> (state_reg == sbc_pkg::ST_ADDR))
      else $error("engine stopped in idle without idle_halt");

   a_release_frees: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (ce_in && rel_sw_set && !halted) |=> (ctrl_reg[sbc_pkg::CTL_RELEASE] && !scl_oe_out))
      else $error("clock not released after writing one");

   a_rx_end_stretch: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (eng_en && mod_on && state_reg == sbc_pkg::ST_RX_ACK && scl_fall && ctrl_reg[sbc_pkg::CTL_STRETCH] && !ctrl_wr)
      |=> (!ctrl_reg[sbc_pkg::CTL_RELEASE] && scl_oe_out))
      else $error("no stretch after received data byte");

   a_addr_end_clears: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (eng_en && mod_on && state_reg == sbc_pkg::ST_ADDR_ACK && scl_fall && !ctrl_wr)
      |=> !ctrl_reg[sbc_pkg::CTL_RELEASE])
      else $error("clock_release not cleared after address byte");

   a_no_sw_stretch: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (ce_in && ctrl_wr && !wdata_in[sbc_pkg::CTL_RELEASE] && !ctrl_reg[sbc_pkg::CTL_STRETCH]
       && ctrl_reg[sbc_pkg::CTL_RELEASE] && !(eng_en && hw_rel_clr)) |=> ctrl_reg[sbc_pkg::CTL_RELEASE])
      else $error("software zero accepted with stretch_allow clear");

   a_rx_keeps_release: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (eng_en && mod_on && state_reg == sbc_pkg::ST_RX_ACK && scl_fall && !ctrl_reg[sbc_pkg::CTL_STRETCH]
       && ctrl_reg[sbc_pkg::CTL_RELEASE] && !ctrl_wr) |=> ctrl_reg[sbc_pkg::CTL_RELEASE])
      else $error("data byte cleared release with stretch_allow clear");

   a_accept_all_ack: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (eng_en && mod_on && accept_all && state_reg == sbc_pkg::ST_ADDR && byte_end)
      |=> (state_reg == sbc_pkg::ST_ADDR_ACK && sda_oe_out))
      else $error("address not acknowledged in accept-all mode");

   a_seven_one_byte: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (eng_en && mod_on && !wide && addr_hit && state_reg == sbc_pkg::ST_ADDR && byte_end)
      |=> !second_reg)
      else $error("second address byte taken in 7-bit mode");

   a_bcast_flag: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (eng_en && mod_on && state_reg == sbc_pkg::ST_ADDR_ACK && scl_fall && !second_reg && is_bcast)
      |=> status_reg[sbc_pkg::EV_BCAST])
      else $error("general call not flagged");

   a_bcast_ignored: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (eng_en && mod_on && state_reg == sbc_pkg::ST_ADDR && byte_end && rx_shift_reg == sbc_pkg::BCAST_ADDR
       && !ctrl_reg[sbc_pkg::CTL_BCAST] && !accept_all && !wide && own_addr_reg[6:0] != 7'h00)
      |=> (state_reg == sbc_pkg::ST_IDLE))
      else $error("general call answered while disabled");
endmodule

// file: include/sbc_pkg.sv
// package: register map, field positions, reset values and states of the serial bus control block
package sbc_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int EV_W = 5;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_OWN_ADDR = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0c;
   localparam logic [7:0] OFF_RX_DATA = 8'h10;
   localparam logic [7:0] OFF_TX_DATA = 8'h14;

   // ****************************************************************
   // bus_control fields
   // ****************************************************************
   localparam int CTL_ON = 15;
   localparam int CTL_IDLE_HALT = 13;
   localparam int CTL_RELEASE = 12;
   localparam int CTL_ACCEPT_ALL = 11;
   localparam int CTL_WIDE = 10;
   localparam int CTL_BCAST = 7;
   localparam int CTL_STRETCH = 6;
   localparam logic [15:0] CTL_RELEASE_MASK = 16'h1000;
   localparam logic [15:0] CTL_WRITABLE = 16'hbfff;
   localparam logic [15:0] CTL_RESET = 16'h1000;

   // ****************************************************************
   // other reset values and event bits
   // ****************************************************************
   localparam logic [9:0] OWN_ADDR_RESET = 10'h000;
   localparam logic [7:0] TX_DATA_RESET = 8'hff;
   localparam int EV_ADDR = 0;
   localparam int EV_RX = 1;
   localparam int EV_BCAST = 2;
   localparam int EV_TX = 3;
   localparam int EV_STOP = 4;

   // ****************************************************************
   // bus protocol constants
   // ****************************************************************
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_ADDR2,
      ST_ADDR2_ACK,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK
   } sbc_state_t;
endpackage

// file: bench/sbc_bus_master.sv
// bench model of the external master on the two-wire link
`timescale 1ns/10ps
module sbc_bus_master (
   output logic scl_out,
   output logic sda_out,
   input wire logic scl_in,
   input wire logic sda_in
);
   logic hung = 1'b0;
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // ****************
   // bit timing, 48 ns clock
   // ****************
   // a stretched clock is waited for, never forever
   task automatic wait_scl();
      int n = 0;
      while (scl_in !== 1'b1 && n < 400) begin
         #5;
         n++;
      end
      if (n >= 400) hung = 1'b1;
   endtask
   task automatic clock_bit(input logic b, output logic s);
      sda_out = b;
      #12 scl_out = 1'b1;
      wait_scl();
      #12 s = sda_in;
      #12 scl_out = 1'b0;
      #12;
   endtask
   task automatic send_start();
      #24 sda_out = 1'b0;
      #24 scl_out = 1'b0;
      #12;
   endtask
   task automatic send_stop();
      sda_out = 1'b0;
      #12 scl_out = 1'b1;
      wait_scl();
      #12 sda_out = 1'b1;
      #24;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
      clock_bit(1'b1, s);
      ack = ~s;
   endtask
   // data line left released so the slave can drive each bit
   task automatic recv_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b1, s);
         d[i] = s;
      end
      clock_bit(nack, s);
   endtask
endmodule

// file: bench/tb_top.sv
// self-checking bench for the serial bus control block
`timescale 1ns/10ps
module tb_top;
   localparam logic [7:0] C = sbc_pkg::OFF_CONTROL;
   localparam logic [7:0] S = sbc_pkg::OFF_STATUS;
   localparam logic [7:0] M = sbc_pkg::OFF_MASK;
   logic clk_sys_in = 1'b0, nrst_in = 1'b0, idle_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [15:0] wdata_in = 16'h0000, rdata_out;
   logic irq_out, pins_owned_out, scl_oe_out, sda_oe_out, m_scl, m_sda, scl_w, sda_w;
   int n_errors = 0;
   int n_compared = 0;
   // ****************
   // open-drain wires, pulled up
   // ****************
   assign scl_w = m_scl & ~scl_oe_out;
   assign sda_w = m_sda & ~sda_oe_out;
   sbc_ctrl dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(1'b1), .idle_in(idle_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .scl_in(scl_w),
      .sda_in(sda_w), .rdata_out(rdata_out), .irq_out(irq_out), .pins_owned_out(pins_owned_out),
      .scl_out(), .scl_oe_out(scl_oe_out), .sda_out(), .sda_oe_out(sda_oe_out));
   sbc_bus_master m_u (.scl_out(m_scl), .sda_out(m_sda), .scl_in(scl_w), .sda_in(sda_w));
   initial begin
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   // ****************
   // shared tasks
   // ****************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] exp, input string m);
      rda(C, exp, m);
   endtask
   task automatic rda(input logic [7:0] a, input logic [15:0] exp, input string m);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, exp, m);
   endtask
   // status cleared first, so each frame starts clean
   task automatic xfer(input bit st, input logic [7:0] d, input logic e, input string m);
      logic a;
      if (st) wr(S, 16'h001f);
      if (st) m_u.send_start();
      m_u.send_byte(d, a);
      chk(16'(a), 16'(e), m);
      chk(16'(m_u.hung), 16'h0000, "link hang");
   endtask
   task automatic held(input logic e, input string m);
      int n = 0;
      while (scl_oe_out !== e && n < 40) begin
         @(posedge clk_sys_in);
         n++;
      end
      chk(16'(scl_oe_out), 16'(e), m);
   endtask
   task automatic irq_is(input logic e, input string m);
      repeat (2) @(posedge clk_sys_in);
      #1 chk(16'(irq_out), 16'(e), m);
   endtask
   task automatic wrap_up();
      $display("n_errors %0d n_compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_enable();
      rd(16'h1000, "ctrl reset");
      wr(sbc_pkg::OFF_OWN_ADDR, 16'h002a);
      xfer(1, 8'h54, 1'b0, "off ignores bus");
      m_u.send_stop();
      wr(C, 16'h8000);
      rd(16'h9000, "release not clearable");
      chk(16'(pins_owned_out), 16'h0001, "pins owned");
   endtask
   task automatic t_match7();
      wr(M, 16'h0000);
      xfer(1, 8'h54, 1'b1, "7-bit ack");
      held(1'b1, "stretch after address");
      rd(16'h8000, "release cleared");
      irq_is(1'b0, "irq masked");
      wr(M, 16'h0001);
      irq_is(1'b1, "irq on match");
      wr(S, 16'h0001);
      irq_is(1'b0, "status cleared");
      wr(C, 16'h9000);
      held(1'b0, "clock released");
      xfer(0, 8'h11, 1'b1, "data ack no stretch");
      rd(16'h9000, "data keeps release");
      m_u.send_stop();
   endtask
   task automatic t_stretch();
      wr(C, 16'h9040);
      xfer(1, 8'h54, 1'b1, "ack");
      wr(C, 16'h9040);
      xfer(0, 8'h3c, 1'b1, "data ack");
      held(1'b1, "stretch after data");
      rd(16'h8040, "release cleared on data");
      rda(sbc_pkg::OFF_RX_DATA, 16'h003c, "received byte");
      wr(C, 16'h9040);
      m_u.send_stop();
      rda(S, 16'h0013, "flags after stop");
      wr(C, 16'h8040);
      rd(16'h8040, "sw clear");
   endtask
   task automatic t_modes();
      wr(C, 16'h9000);
      xfer(1, 8'h66, 1'b0, "no match");
      m_u.send_stop();
      wr(C, 16'h9800);
      xfer(1, 8'h66, 1'b1, "accept all");
      wr(C, 16'h9800);
      m_u.send_stop();
      wr(C, 16'h9000);
      xfer(1, 8'h00, 1'b0, "call ignored");
      m_u.send_stop();
      wr(C, 16'h9080);
      wr(M, 16'h0004);
      xfer(1, 8'h00, 1'b1, "call ack");
      irq_is(1'b1, "call irq");
      wr(C, 16'h9080);
      m_u.send_stop();
      wr(C, 16'hb000);
      idle_in <= 1'b1;
      xfer(1, 8'h54, 1'b0, "halted in idle");
      m_u.send_stop();
      wr(C, 16'h9000);
      xfer(1, 8'h54, 1'b1, "runs in idle");
      wr(C, 16'h9000);
      m_u.send_stop();
      idle_in <= 1'b0;
      wr(sbc_pkg::OFF_OWN_ADDR, 16'h02a5);
      wr(C, 16'h9400);
      xfer(1, 8'hf4, 1'b1, "10-bit first");
      wr(C, 16'h9400);
      xfer(0, 8'ha5, 1'b1, "10-bit second");
      wr(C, 16'h9400);
      m_u.send_stop();
   endtask
   task automatic t_tx();
      logic [7:0] d;
      wr(sbc_pkg::OFF_OWN_ADDR, 16'h002a);
      wr(sbc_pkg::OFF_TX_DATA, 16'h00c3);
      wr(C, 16'h9000);
      xfer(1, 8'h55, 1'b1, "read ack");
      held(1'b1, "stretch before transmit");
      rd(16'h8000, "release cleared on transmit");
      rda(S, 16'h0009, "match and transmit flags");
      wr(C, 16'h9000);
      m_u.recv_byte(1'b1, d);
      chk(16'(d), 16'h00c3, "transmit data");
      chk(16'(m_u.hung), 16'h0000, "link hang");
      m_u.send_stop();
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      t_enable();
      t_match7();
      t_stretch();
      t_modes();
      t_tx();
      wrap_up();
   end
endmodule
